/* File: rtl/pwm_meter_pkg.sv */
// package: register map, control layout, timing constants and types of the pulse meter
package pwm_meter_pkg;

  // ************************************************************
  // register indices and byte addresses
  // ************************************************************
  localparam logic [3:0] IDX_BOARD = 4'h0;
  localparam logic [3:0] IDX_IRQ = 4'h2;
  localparam logic [3:0] IDX_TRIG = 4'h4;
  localparam logic [7:0] ADDR_BOARD = {2'b00, IDX_BOARD, 2'b00};
  localparam logic [7:0] ADDR_IRQ = {2'b00, IDX_IRQ, 2'b00};
  localparam logic [7:0] ADDR_TRIG = {2'b00, IDX_TRIG, 2'b00};
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_READBACK = 8'h24;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic BOARD_RESET = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ************************************************************
  // control field encodings
  // ************************************************************
  localparam logic [2:0] MODE_PULSE_WIDTH = 3'b101;
  localparam logic [2:0] MODE_PERIOD = 3'b110;
  localparam logic [1:0] POL_LOW = 2'b01;
  localparam logic [1:0] POL_HIGH = 2'b10;
  localparam logic [2:0] SRC_INT_MAX = 3'b100;
  localparam logic [2:0] SRC_EXTERNAL = 3'b101;
  localparam logic [15:0] COUNT_FULL = 16'hFFFF;

  typedef struct packed {
    logic irq_enable;      // bit 15
    logic unused;          // bit 14
    logic debounce;        // bit 13
    logic [2:0] clk_src;   // bits 12:10
    logic [1:0] trig_pol;  // bits 9:8
    logic [1:0] ext_pol;   // bits 7:6
    logic [1:0] in_pol;    // bits 5:4
    logic out_pol;         // bit 3
    logic [2:0] mode;      // bits 2:0
  } ctrl_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WAIT = 3'b001,
    S_ACTIVE = 3'b010,
    S_INACTIVE = 3'b011
  } meas_state_t;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_FREQ_KHZ = 25000;
  localparam int DEBOUNCE_NS = 2500;
  // reject pulses up to and including the debounce time
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int OUT_PULSE_NS = 1750;
  localparam int OUT_PULSE_CYC = (OUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BASE_KHZ_8M = 500;
  localparam int BASE_KHZ_32M = 2000;

  // phase increment of a 16-bit accumulator for the selected internal clock
  function automatic logic [16:0] rate_inc(input logic [2:0] src, input logic c32);
    longint f_khz;
    longint inc;
    f_khz = (c32 ? longint'(BASE_KHZ_32M) : longint'(BASE_KHZ_8M)) << src;
    inc = (f_khz * 65536) / longint'(CLK_FREQ_KHZ);
    if (inc > 65536) begin
      inc = 65536;
    end
    return inc[16:0];
  endfunction

endpackage

/* File: rtl/pulse_width_period_meter.sv */
// module: pulse-width and period meter channel with an AXI4-Lite register slave
// ************************************************************
// Overview of operation
// - control mode 101 selects pulse-width measurement.
// - control mode 110 selects period measurement of the measured input.
// - each trigger measures only the first following pulse or cycle, then stops.
// - bits 5:4 set input level: 01 low, 10 high, 00/11 disabled.
// - external clock counted only with bits 7:6 at 01/10 and source 101.
// - source codes 000..100 pick internal clocks scaled by carrier rate.
// - bits 9:8 make trigger input active low (01) or high (10).
// - writing trigger register bit starts measurement like an external trigger.
// - after trigger, counting waits for the next active pulse or period.
// - pulse-width: clear on trigger, count clock ticks while input active.
// - period: clear on trigger, count across one full active-plus-inactive cycle.
// - each completion drives an output pulse of 1.75 us.
// - control bit 3 sets output pulse level; pin rests high undriven.
// - an interval beyond range reads back as 0xFFFF.
// - with bit 15 set, pulse-width completion raises the interrupt.
// - with bit 15 set, period completion after first full cycle raises interrupt.
// - period interrupt still occurs with a silent external clock; count reads zero.
// - interrupt stays pending until status register bit is written.
// - writing bit 15 as zero clears a pending interrupt.
// - bit 13 enables debounce rejecting pulses of 2.5 us or less.
// - control bit 14 always reads zero.
// ************************************************************
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps

module pulse_width_period_meter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // channel pins
  input wire logic measured_input,
  input wire logic ext_clock_input,
  input wire logic trigger_input,
  output logic channel_out,
  output logic channel_out_oe,
  output logic irq
);
  import pwm_meter_pkg::*;

  // ************************************************************
  // registers and state
  // ************************************************************
  ctrl_t ctrl;
  logic carrier_32;
  logic irq_pending;
  logic [15:0] count;
  meas_state_t state;
  logic [7:0] awaddr_q;
  logic aw_held;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held;
  logic wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ctrl;
  logic sw_trigger;
  logic irq_clear;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] clean;
  logic [2:0] clean_prev;
  logic [7:0] deb_cnt [3];
  logic [15:0] phase;
  logic [16:0] rate;
  logic tick;
  logic in_active;
  logic in_active_prev;
  logic trig_active;
  logic trig_active_prev;
  logic ext_trigger;
  logic trigger;
  logic mode_valid;
  logic ext_clk_sel;
  logic complete;
  logic [7:0] pulse_cnt;
  logic pulse_active;

  // ************************************************************
  // axi4-lite write path
  // ************************************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_addr = aw_held ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held ? wdata_q : s_axi_wdata;
  assign wr_strb = w_held ? wstrb_q : s_axi_wstrb;
  assign wr_go = !s_axi_bvalid && (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (wr_addr == ADDR_BOARD || wr_addr == ADDR_IRQ || wr_addr == ADDR_TRIG ||
          wr_addr == ADDR_CTRL || wr_addr == ADDR_READBACK) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_ctrl = wr_go && wr_addr == ADDR_CTRL && wr_strb[1:0] != 2'b00;
  assign sw_trigger = wr_go && wr_addr == ADDR_TRIG && wr_strb[0] && wr_data[0];
  assign irq_clear = wr_go && wr_addr == ADDR_IRQ && wr_strb[0] && wr_data[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= ctrl_t'(CTRL_RESET);
    end else if (wr_ctrl) begin
      if (wr_strb[0]) begin
        ctrl[7:0] <= wr_data[7:0];
      end
      if (wr_strb[1]) begin
        ctrl[15:8] <= {wr_data[15], 1'b0, wr_data[13:8]};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_32 <= BOARD_RESET;
    end else if (wr_go && wr_addr == ADDR_BOARD && wr_strb[0]) begin
      carrier_32 <= wr_data[0];
    end
  end

  // ************************************************************
  // axi4-lite read path
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == ADDR_BOARD) begin
        s_axi_rdata <= {31'h0000_0000, carrier_32};
      end else if (s_axi_araddr == ADDR_IRQ) begin
        s_axi_rdata <= {31'h0000_0000, irq_pending};
      end else if (s_axi_araddr == ADDR_TRIG) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_araddr == ADDR_CTRL) begin
        s_axi_rdata <= {16'h0000, ctrl};
      end else if (s_axi_araddr == ADDR_READBACK) begin
        s_axi_rdata <= {16'h0000, count};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // input synchronisers and debounce
  // ************************************************************
  // index 0 measured input, 1 external clock, 2 trigger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 3'b000;
      sync2 <= 3'b000;
    end else begin
      sync1 <= {trigger_input, ext_clock_input, measured_input};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clean <= 3'b000;
      clean_prev <= 3'b000;
      for (int i = 0; i < 3; i++) begin
        deb_cnt[i] <= 8'h00;
      end
    end else begin
      clean_prev <= clean;
      for (int i = 0; i < 3; i++) begin
        if (!ctrl.debounce || sync2[i] == clean[i]) begin
          deb_cnt[i] <= 8'h00;
          clean[i] <= sync2[i];
        end else if (deb_cnt[i] == 8'(DEBOUNCE_CYC - 1)) begin
          deb_cnt[i] <= 8'h00;
          clean[i] <= sync2[i];
        end else begin
          deb_cnt[i] <= deb_cnt[i] + 8'h01;
        end
      end
    end
  end

  // ************************************************************
  // count clock selection
  // ************************************************************
  assign ext_clk_sel = (ctrl.ext_pol == POL_LOW || ctrl.ext_pol == POL_HIGH) &&
                       ctrl.clk_src == SRC_EXTERNAL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 16'h0000;
    end else begin
      phase <= phase + rate[15:0];
    end
  end

  assign rate = rate_inc(ctrl.clk_src, carrier_32);

  always_comb begin
    logic [16:0] sum;
    sum = {1'b0, phase} + {1'b0, rate[15:0]};
    if (ext_clk_sel) begin
      tick = clean[1] && !clean_prev[1];
    end else if (ctrl.clk_src <= SRC_INT_MAX) begin
      tick = rate[16] || sum[16];
    end else begin
      tick = 1'b0;
    end
  end

  // ************************************************************
  // trigger and input level decode
  // ************************************************************
  assign in_active = (ctrl.in_pol == POL_LOW && !clean[0]) ||
                     (ctrl.in_pol == POL_HIGH && clean[0]);
  assign in_active_prev = (ctrl.in_pol == POL_LOW && !clean_prev[0]) ||
                          (ctrl.in_pol == POL_HIGH && clean_prev[0]);
  assign trig_active = (ctrl.trig_pol == POL_LOW && !clean[2]) ||
                       (ctrl.trig_pol == POL_HIGH && clean[2]);
  assign trig_active_prev = (ctrl.trig_pol == POL_LOW && !clean_prev[2]) ||
                            (ctrl.trig_pol == POL_HIGH && clean_prev[2]);
  assign ext_trigger = trig_active && !trig_active_prev;
  assign trigger = ext_trigger || sw_trigger;
  assign mode_valid = ctrl.mode == MODE_PULSE_WIDTH || ctrl.mode == MODE_PERIOD;

  // ************************************************************
  // measurement sequencer
  // ************************************************************
  always_comb begin
    complete = 1'b0;
    if (mode_valid && !trigger) begin
      if (state == S_ACTIVE && !in_active && ctrl.mode == MODE_PULSE_WIDTH) begin
        complete = 1'b1;
      end else if (state == S_INACTIVE && in_active && !in_active_prev) begin
        complete = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
    end else if (!mode_valid) begin
      state <= S_IDLE;
    end else if (trigger) begin
      state <= S_WAIT;
    end else begin
      case (state)
        S_WAIT: begin
          if (in_active && !in_active_prev) begin
            state <= S_ACTIVE;
          end
        end
        S_ACTIVE: begin
          if (!in_active) begin
            state <= (ctrl.mode == MODE_PERIOD) ? S_INACTIVE : S_IDLE;
          end
        end
        S_INACTIVE: begin
          if (complete) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 16'h0000;
    end else if (trigger && mode_valid) begin
      count <= 16'h0000;
    end else if (tick && count != COUNT_FULL &&
                 ((state == S_ACTIVE && in_active) || state == S_INACTIVE)) begin
      count <= count + 16'h0001;
    end
  end

  // ************************************************************
  // completion pulse and interrupt
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt <= 8'h00;
    end else if (complete) begin
      pulse_cnt <= 8'(OUT_PULSE_CYC);
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  assign pulse_active = pulse_cnt != 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_out <= 1'b1;
      channel_out_oe <= 1'b0;
    end else begin
      channel_out <= pulse_active ? ctrl.out_pol : 1'b1;
      channel_out_oe <= pulse_active;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pending <= 1'b0;
    end else if (complete && ctrl.irq_enable) begin
      irq_pending <= 1'b1;
    end else if (irq_clear) begin
      irq_pending <= 1'b0;
    end else if (wr_ctrl && wr_strb[1] && !wr_data[15]) begin
      irq_pending <= 1'b0;
    end
  end

  assign irq = irq_pending;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_saturate;
    count == COUNT_FULL && !trigger |=> count == COUNT_FULL;
  endproperty
  a_saturate: assert property (p_saturate) else $error("count left saturation");

  property p_pw_done;
    state == S_ACTIVE && ctrl.mode == MODE_PULSE_WIDTH && !in_active && !trigger
      |=> state == S_IDLE && pulse_cnt == 8'(OUT_PULSE_CYC);
  endproperty
  a_pw_done: assert property (p_pw_done) else $error("pulse end not completed");

  property p_pulse_len;
    complete ##1 !complete [*8] |-> ##1 channel_out_oe;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("output pulse too short");

  property p_pulse_end;
    pulse_cnt == 8'h01 && !complete |=> ##1 !channel_out_oe;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("output pulse too long");

  property p_irq_set;
    complete && ctrl.irq_enable |=> irq ##1 (irq || $past(irq_clear) || $past(wr_ctrl));
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");

  property p_irq_ie_clear;
    wr_ctrl && wr_strb[1] && !wr_data[15] && !complete |=> !irq;
  endproperty
  a_irq_ie_clear: assert property (p_irq_ie_clear) else $error("enable clear kept irq");

  property p_irq_hold;
    irq && !irq_clear && !wr_ctrl |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");

  property p_trigger_clear;
    trigger && mode_valid |=> count == 16'h0000 && state == S_WAIT;
  endproperty
  a_trigger_clear: assert property (p_trigger_clear) else $error("trigger did not rearm");

  property p_bit14;
    ctrl.unused == 1'b0;
  endproperty
  a_bit14: assert property (p_bit14) else $error("control bit 14 set");

  property p_out_level;
    channel_out_oe |-> channel_out == $past(ctrl.out_pol);
  endproperty
  a_out_level: assert property (p_out_level) else $error("wrong output level");

  c_pw_done: cover property (complete && ctrl.mode == MODE_PULSE_WIDTH);
  c_period_done: cover property (complete && ctrl.mode == MODE_PERIOD);
  c_sat: cover property (count == COUNT_FULL && state != S_IDLE);
  c_irq_clear: cover property (irq ##1 !irq);

endmodule

/* File: verification/pulse_src.sv */
// behavioural far side: measured waveform and external clock source
`timescale 1ns/1ps

module pulse_src (
  // clock
  input wire logic aclk,
  // waveform command
  input wire logic go,
  input wire logic act_lvl,
  input wire logic [31:0] act_cyc,
  input wire logic [31:0] inact_cyc,
  input wire logic [31:0] n_pulse,
  input wire logic [31:0] ext_half,
  // pins and status
  output logic measured_input,
  output logic ext_clock_input,
  output logic busy
);
  // ************************************************************
  // waveform generation
  // ************************************************************
  initial begin
    measured_input = 1'b0;
    ext_clock_input = 1'b0;
    busy = 1'b0;
  end
  // a run is inactive/active pairs, then inactive again; idle stays inactive
  always begin
    @(posedge aclk);
    if (go) begin
      busy <= 1'b1;
      for (int k = 0; k < n_pulse; k++) begin
        measured_input <= !act_lvl;
        repeat (inact_cyc) @(posedge aclk);
        measured_input <= act_lvl;
        repeat (act_cyc) @(posedge aclk);
      end
      measured_input <= !act_lvl;
      repeat (inact_cyc) @(posedge aclk);
      busy <= 1'b0;
    end else begin
      measured_input <= !act_lvl;
    end
  end
  // external clock stands still outside a run
  always begin
    @(posedge aclk);
    if (busy && ext_half > 0) begin
      repeat (ext_half - 1) @(posedge aclk);
      ext_clock_input <= !ext_clock_input;
    end
  end
endmodule

/* File: verification/pulse_width_period_meter_tb.sv */
// testbench: register access and measurement scenarios of the pulse meter
`timescale 1ns/1ps

module pulse_width_period_meter_tb;
  import pwm_meter_pkg::*;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, act_cyc, inact_cyc, n_pulse, ext_half;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic measured_input, ext_clock_input, trigger_input, channel_out, channel_out_oe, irq;
  logic go, act_lvl, busy, tpol, oe_q;
  int fails, n_tests, outs, o;

  pulse_width_period_meter dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .measured_input, .ext_clock_input, .trigger_input,
    .channel_out, .channel_out_oe, .irq);
  pulse_src src (.aclk, .go, .act_lvl, .act_cyc, .inact_cyc, .n_pulse, .ext_half,
    .measured_input, .ext_clock_input, .busy);

  always #20 aclk = !aclk;
  // counts completion pulses
  always @(posedge aclk) begin
    oe_q <= channel_out_oe;
    if (!oe_q && channel_out_oe === 1'b1) outs <= outs + 1;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task near(input logic [31:0] seen, input int lo, input int hi);
    check({31'd0, (seen >= lo) && (seen <= hi)}, 32'd1);
  endtask
  task summarize;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task wait_out(input logic lvl);
    int n;
    n = 0;
    while (channel_out_oe !== 1'b1) @(posedge aclk);
    check(channel_out, lvl);
    while (channel_out_oe === 1'b1) begin
      n++;
      @(posedge aclk);
    end
    check(n, OUT_PULSE_CYC);
    check(channel_out, 1'b1);
  endtask
  // d > 0: software trigger d cycles into the run, 0: before it, < 0: pin trigger
  task meas(input logic [31:0] c, input logic l, input int a, input int i, input int n,
            input int d);
    o = outs;
    trigger_input <= !tpol;
    act_lvl <= l;
    act_cyc <= a;
    inact_cyc <= i;
    n_pulse <= n;
    wr(ADDR_CTRL, c);
    if (d == 0) wr(ADDR_TRIG, 32'h0000_0001);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (d > 0 ? d : 3) @(posedge aclk);
    if (d > 0) wr(ADDR_TRIG, 32'h0000_0001);
    if (d < 0) begin
      trigger_input <= tpol;
      repeat (5) @(posedge aclk);
      trigger_input <= !tpol;
    end
    @(posedge aclk);
    while (busy === 1'b1) @(posedge aclk);
    repeat (60) @(posedge aclk);
    rd(ADDR_READBACK, v);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs;
    check(channel_out, 1'b1);
    check(irq, 1'b0);
    rd(ADDR_CTRL, v);
    check(v, {16'h0000, CTRL_RESET});
    rd(ADDR_BOARD, v);
    check(v, {31'd0, BOARD_RESET});
    wr(ADDR_CTRL, 32'h0000_FFFF);
    check(r, RESP_OKAY);
    rd(ADDR_CTRL, v);
    check(v, 32'h0000_BFFF);
    rd(8'h3C, v);
    check(r, RESP_SLVERR);
    wr(8'h3C, 32'h0000_0000);
    check(r, RESP_SLVERR);
    wr(ADDR_CTRL, 32'h0000_0000);
  endtask
  task t_pw;
    wr(ADDR_BOARD, 32'h0000_0001);
    fork
      meas(32'h0000_902D, 1'b1, 200, 100, 3, 120);
      wait_out(1'b1);
    join
    near(v, 198, 202);
    check(outs - o, 1);
    check(irq, 1'b1);
    rd(ADDR_IRQ, v);
    check(v, 32'h0000_0001);
    wr(ADDR_IRQ, 32'h0000_0001);
    check(irq, 1'b0);
  endtask
  task t_per;
    fork
      meas(32'h0000_9016, 1'b0, 60, 90, 3, 0);
      wait_out(1'b0);
    join
    near(v, 148, 152);
    check(irq, 1'b1);
    wr(ADDR_CTRL, 32'h0000_1016);
    check(irq, 1'b0);
  endtask
  task t_src;
    int f;
    int e;
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 5; s++) begin
        f = (b == 1 ? 2000 : 500) << s;
        if (f > 25000) f = 25000;
        e = 500 * f / 25000;
        wr(ADDR_BOARD, 32'(b));
        meas(32'h0000_8025 | (32'(s) << 10), 1'b1, 500, 100, 1, 0);
        near(v, e - 2, e + 2);
      end
    end
  endtask
  task t_ext;
    ext_half <= 5;
    meas(32'h0000_94A5, 1'b1, 200, 100, 1, 0);
    near(v, 18, 22);
    wr(ADDR_IRQ, 32'h0000_0001);
    ext_half <= 0;
    meas(32'h0000_9466, 1'b1, 60, 90, 3, 0);
    check(v, 32'h0000_0000);
    check(irq, 1'b1);
  endtask
  task t_trig;
    for (int p = 0; p < 3; p++) begin
      tpol = (p == 2);
      meas(32'h0000_9025 | (32'(p) << 8), 1'b1, 100, 100, 1, -1);
      check(outs - o, p != 0);
    end
    near(v, 98, 102);
    for (int q = 0; q < 4; q += 3) begin
      meas(32'h0000_9005 | (32'(q) << 4), 1'b1, 100, 100, 1, 0);
      check(outs - o, 0);
    end
  endtask
  task t_deb;
    meas(32'h0000_B025, 1'b1, 50, 100, 1, 0);
    check(outs - o, 0);
    meas(32'h0000_B025, 1'b1, 200, 100, 1, -1);
    near(v, 197, 203);
  endtask
  task t_ovf;
    wr(ADDR_BOARD, 32'h0000_0001);
    meas(32'h0000_9025, 1'b1, 66000, 100, 1, 0);
    check(v, {16'h0000, COUNT_FULL});
  endtask

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, go, act_lvl, trigger_input, oe_q, tpol} = 6'b000001;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {act_cyc, inact_cyc, n_pulse, ext_half} = '0;
    {fails, n_tests, outs, o} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_pw;
    t_per;
    t_src;
    t_ext;
    t_trig;
    t_deb;
    t_ovf;
    summarize;
  end
  initial begin
    repeat (95000) @(posedge aclk);
    fails++;
    summarize;
  end
endmodule
